// >>> dv/act_ctrl_chk.sv
/*
 Concurrent checks on the act_ctrl ports.
 Bound to every act_ctrl instance; one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module act_ctrl_chk #(
   parameter int PWRUP_CYC = 20,
   parameter int CAL_CYC   = 10
)(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        samp_clk_en,
   input wire logic        supplies_ok,
   input wire logic        sysref_in,
   input wire logic        sysref_seen,
   input wire logic [1:0]  clock_divide_setting,
   input wire logic        cal_active,
   input wire logic        link_reinit,
   input wire logic [4:0]  multiframe_k,
   input wire logic [3:0]  test_select,
   input wire logic        tx_word_valid
);
   int ccnt;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Enables seen while calibrating, to bound its length
   always_ff @(posedge aclk) begin
      if (!aresetn || !cal_active)
         ccnt <= 0;
      else if (samp_clk_en)
         ccnt <= ccnt + 1;
   end
   AST_BV_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid) else $error("write response dropped early");
   AST_AW_REFUSE: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready) else $error("write taken too soon");
   AST_RV_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
   AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken too soon");
   AST_SYSREF: assert property ($rose(sysref_in) |-> ##[1:2]
      sysref_seen) else $error("sysref edge missed");
   AST_K_MIN: assert property (multiframe_k >= 5'h08)
      else $error("multiframe length below minimum");
   AST_TP_MAX: assert property (test_select <= 4'h7)
      else $error("unsupported test sequence");
   AST_WORD: assert property (1'b1 |=>
      tx_word_valid == $past(samp_clk_en)) else $error("word valid late");
   AST_REINIT: assert property ($changed(clock_divide_setting) |->
      ##[0:1] link_reinit) else $error("no link reinit on divide change");
   AST_PWR_LOSS: assert property (!supplies_ok |=> !cal_active)
      else $error("calibration kept without supplies");
   AST_CAL_LEN: assert property (cal_active |-> ccnt <= CAL_CYC)
      else $error("calibration too long");
   AST_CAL_MIN: assert property ($fell(cal_active) && $past(supplies_ok)
      |-> ccnt >= CAL_CYC - 1) else $error("calibration too short");
   cover property ($fell(cal_active));
   cover property (link_reinit);
   cover property (s_axi_rvalid && s_axi_rready);
endmodule : act_ctrl_chk
bind act_ctrl act_ctrl_chk #(.PWRUP_CYC(PWRUP_CYC), .CAL_CYC(CAL_CYC))
   u_act_ctrl_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .samp_clk_en(samp_clk_en), .supplies_ok(supplies_ok),
   .sysref_in(sysref_in), .sysref_seen(sysref_seen),
   .clock_divide_setting(clock_divide_setting),
   .cal_active(cal_active), .link_reinit(link_reinit),
   .multiframe_k(multiframe_k), .test_select(test_select),
   .tx_word_valid(tx_word_valid));
`default_nettype wire

// >>> dv/act_rx_model.sv
/*
 Lane receiver stand-in: keeps the last two words taken from the lane.
 Assumes words come already formatted, one per valid pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module act_rx_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [15:0] tx_word,
   input  wire logic        tx_word_valid,
   output logic      [15:0] last_word,
   output logic      [15:0] prev_word
);
   // No ILA or K checks here, so only word content is judged
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_word <= 16'h0000;
         prev_word <= 16'h0000;
      end else if (tx_word_valid) begin
         prev_word <= last_word;
         last_word <= tx_word;
      end
   end
endmodule : act_rx_model
`default_nettype wire

// >>> dv/tb_adc_cal_and_serial_tx_config.sv
/*
 Bench for act_ctrl: AXI4-Lite register tasks, calibration, format, link.
 Assumes short power-up and calibration counts set below.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_adc_cal_and_serial_tx_config;
   import act_pkg::*;
   localparam int PW = 20;
   localparam int CC = 10;
   localparam logic [31:0] PRM = {ACT_BITS_PER_LANE, ACT_SUBCLASS,
      ACT_SAMPLES, ACT_LANES, ACT_OCTETS, 6'h00};
   logic aclk = 0, aresetn = 0, samp = 0, sup = 0, sref = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, d;
   logic [3:0] wstrb = 0, tsel;
   logic [13:0] smp = 0;
   logic [1:0] bresp, rresp, cdiv, r;
   logic awready, wready, bvalid, arready, rvalid, cal, reinit, scr, ss, twv;
   logic [4:0] mk;
   logic [15:0] tw, lw, pw, dw;
   int bad_count = 0, cmp_count = 0, cyc = 0, rcnt = 0, n, i;
   act_ctrl #(.PWRUP_CYC(PW), .CAL_CYC(CC)) u_act_ctrl (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .samp_clk_en(samp),
      .supplies_ok(sup), .sysref_in(sref), .sample_in(smp),
      .clock_divide_setting(cdiv), .cal_active(cal), .link_reinit(reinit),
      .scramble_en(scr), .multiframe_k(mk), .test_select(tsel),
      .sysref_seen(ss), .tx_word(tw), .tx_word_valid(twv));
   act_rx_model u_act_rx_model (.aclk(aclk), .aresetn(aresetn),
      .tx_word(tw), .tx_word_valid(twv), .last_word(lw), .prev_word(pw));
   always #2.5 aclk = ~aclk;
   // Sampling clock at half the bus clock
   always @(posedge aclk) samp <= aresetn && !samp;
   always @(posedge aclk) begin
      if (reinit === 1'b1) rcnt++;
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         end_of_test();
      end
   end
   task automatic end_of_test;
      if (bad_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   // Ready sampled at the edge; each valid dropped right after its edge
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         r = bresp;
      end while (!bvalid);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         d = rdata;
         r = rresp;
      end while (!rvalid);
      rready <= 1'b0;
   endtask : rd
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(d, e);
      chk(r, 2'h0);
   endtask : rc
   task automatic hold(input logic v);
      n = 0;
      @(negedge aclk);
      while (cal === v) begin
         n++;
         @(negedge aclk);
      end
   endtask : hold
   task automatic fm(input logic [13:0] s, input logic [15:0] e);
      smp <= s;
      repeat (6) @(posedge aclk);
      chk(lw, e);
   endtask : fm
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rc(ACT_OFS_CTRL, 32'h0);
      rc(ACT_OFS_LINK, 32'h0010_1f00);
      rc(ACT_OFS_PARAM, PRM);
      rc(ACT_OFS_ID, ACT_ID_VALUE);
      rd(8'h18);
      chk(d, 32'h0);
      chk(r, 2'h2);
      wr(8'h1c, 32'h1);
      chk(r, 2'h2);
      sup <= 1'b1;
      repeat (10) @(posedge aclk);
      sup <= 1'b0;
      repeat (3) @(posedge aclk);
      sup <= 1'b1;
      hold(1'b0);
      chk(n > 2 * PW - 4 && n < 2 * PW + 4, 1);
      hold(1'b1);
      chk(n > 2 * CC - 4 && n < 2 * CC + 4, 1);
      rc(ACT_OFS_STATUS, 32'h1);
      for (i = 1; i <= 4; i++) begin
         wr(ACT_OFS_DIV, i % 4);
         rc(ACT_OFS_DIV, i % 4);
         chk(cdiv, i % 4);
         chk(rcnt, i);
      end
      wr(ACT_OFS_CTRL, 32'h1);
      rc(ACT_OFS_STATUS, 32'h0);
      wr(ACT_OFS_CTRL, 32'h0);
      rc(ACT_OFS_STATUS, 32'h2);
      hold(1'b1);
      rc(ACT_OFS_STATUS, 32'h1);
      fm(14'h1234, 16'h48d0);
      fm(14'h2000, 16'h8000);
      wr(ACT_OFS_CTRL, 32'h2);
      fm(14'h2000, 16'h0000);
      fm(14'h1234, 16'hc8d0);
      wr(ACT_OFS_CTRL, 32'h0);
      for (i = 0; i <= 8; i++) begin
         wr(ACT_OFS_LINK, 32'h0010_0000 | i << 16 | (i + 5) << 8 | i & 1);
         rc(ACT_OFS_LINK, 32'h0010_0000 | (i > 7 ? 0 : i) << 16 |
            (i < 3 ? 8 : i + 5) << 8 | i & 1);
         chk({scr, tsel}, (i & 1) << 4 | (i > 7 ? 0 : i));
         chk(mk, i < 3 ? 8 : i + 5);
      end
      wr(ACT_OFS_LINK, 32'h0037_1f00);
      repeat (6) @(posedge aclk);
      dw = lw - pw;
      chk(dw, 16'h0003);
      for (i = 0; i < 4; i++) begin
         sref <= i != 1;
         @(posedge aclk);
         sref <= 1'b0;
         repeat (3) @(posedge aclk);
         chk(ss, i != 1);
         rc(ACT_OFS_STATUS, i == 1 ? 32'h1 : 32'h9);
         wr(ACT_OFS_STATUS, 32'h8);
      end
      end_of_test();
   end
endmodule : tb_adc_cal_and_serial_tx_config
`default_nettype wire

// >>> rtl/act_ctrl.sv
/*
 Calibration sequencing and serial-link configuration control with an
 AXI4-Lite register slave and the sample formatter in its path.
 Assumes samp_clk_en is a one-cycle pulse per sampling clock, made from
 the divided device clock outside, and supplies_ok is synchronous.
*/
// The address map and the AXI4-Lite register port are this design's own decisions.
// Contract
// - Wait power-up delay, then calibrate automatically.
// - Calibration lasts about one million samples.
// - Power-down then normal starts manual calibration.
// - Two's complement default, offset binary selectable.
// - Formatting precedes framing, scrambling, encoding.
// - Subclass 1 only, deterministic latency.
// - Accept periodic, burst or single SYSREF.
// - No lane polarity inversion; AC coupled.
// - Frame parameters fixed by one lane.
// - Only K and scrambling configurable; the link register also sets the test choice and the ramp step.
// - D21.5, K28.5, ILA, PRBS, ramp tests only.
// - Exactly one serial lane.
// - Lane rate twenty times sample rate.
// - Device clock divided by 1, 2, 4, 8.
// - Divide change re-initializes the link.
// - Scrambling off at reset; ILA unscrambled.
`timescale 1ns/10ps
`default_nettype none
module act_ctrl
   import act_pkg::*;
#(
   parameter int PWRUP_CYC = ACT_PWRUP_CYC,
   parameter int CAL_CYC   = ACT_CAL_CYC
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        samp_clk_en,
   input  wire logic        supplies_ok,
   input  wire logic        sysref_in,
   input  wire logic [13:0] sample_in,
   output logic [1:0]       clock_divide_setting,
   output logic             cal_active,
   output logic             link_reinit,
   output logic             scramble_en,
   output logic [4:0]       multiframe_k,
   output logic [3:0]       test_select,
   output logic             sysref_seen,
   output logic [15:0]      tx_word,
   output logic             tx_word_valid
);
   typedef struct packed {
      logic [1:0]  wr_got;   // bit1 address, bit0 data taken
      logic [7:0]  wr_addr;
      logic [31:0] wr_data;
      logic [3:0]  wr_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        pdn;
      logic        ofsbin;
      logic [1:0]  div_sel;
      logic        scr;
      logic [4:0]  k;
      logic [3:0]  tp;
      logic [7:0]  step;
      act_cal_e    cal;
      logic [23:0] cnt;
      logic        cal_done;
      logic        reinit;
      logic        sysref_d;
      logic        sysref_ev;
   } act_ctl_s;

   act_ctl_s    st_r;
   act_ctl_s    st_nxt;
   logic [31:0] rd_mux;
   logic [15:0] fmt_word;
   logic        fmt_vld;

   localparam logic [23:0] PWRUP_LAST = 24'(PWRUP_CYC - 1);
   localparam logic [23:0] CAL_LAST   = 24'(CAL_CYC - 1);

   always_comb begin
      case (st_r.wr_addr)
         default: rd_mux = 32'h0000_0000;
      endcase
      case (s_axi_araddr)
         ACT_OFS_CTRL:   rd_mux = {30'h0, st_r.ofsbin, st_r.pdn};
         ACT_OFS_DIV:    rd_mux = {30'h0, st_r.div_sel};
         ACT_OFS_LINK:   rd_mux = {4'h0, st_r.step, st_r.tp, 3'h0, st_r.k,
                                   7'h0, st_r.scr};
         ACT_OFS_STATUS: rd_mux = {28'h0, st_r.sysref_ev, st_r.reinit,
                                   (st_r.cal == ACT_CS_CAL), st_r.cal_done};
         // Fixed lane, frame and subclass values
         ACT_OFS_PARAM:  rd_mux = {ACT_BITS_PER_LANE, ACT_SUBCLASS,
                                   ACT_SAMPLES, ACT_LANES, ACT_OCTETS,
                                   3'h0, 3'h0};
         ACT_OFS_ID:     rd_mux = ACT_ID_VALUE;
         default:        rd_mux = 32'h0000_0000;
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.reinit = 1'b0;
      // Edge capture works for periodic, burst or one-shot alike
      st_nxt.sysref_d = sysref_in;
      if (sysref_in && !st_r.sysref_d) begin
         st_nxt.sysref_ev = 1'b1;
      end

      // Write channel: address and data in either order
      if (s_axi_awvalid && !st_r.wr_got[1] && !st_r.bvalid) begin
         st_nxt.wr_got[1] = 1'b1;
         st_nxt.wr_addr   = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_r.wr_got[0] && !st_r.bvalid) begin
         st_nxt.wr_got[0] = 1'b1;
         st_nxt.wr_data   = s_axi_wdata;
         st_nxt.wr_strb   = s_axi_wstrb;
      end
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (st_r.wr_got == 2'b11) begin
         st_nxt.wr_got = 2'b00;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = 2'b00;
         case (st_r.wr_addr)
            ACT_OFS_CTRL: begin
               if (st_r.wr_strb[0]) begin
                  st_nxt.pdn    = st_r.wr_data[ACT_CTRL_PDN];
                  st_nxt.ofsbin = st_r.wr_data[ACT_CTRL_OFSBIN];
               end
            end
            ACT_OFS_DIV: begin
               if (st_r.wr_strb[0]) begin
                  st_nxt.div_sel = st_r.wr_data[1:0];
                  if (st_r.wr_data[1:0] != st_r.div_sel) begin
                     st_nxt.reinit = 1'b1;
                  end
               end
            end
            ACT_OFS_LINK: begin
               // Only K, scrambling, test choice and ramp step can change
               if (st_r.wr_strb[0]) begin
                  st_nxt.scr = st_r.wr_data[ACT_LINK_SCR];
               end
               if (st_r.wr_strb[1]) begin
                  st_nxt.k = (st_r.wr_data[ACT_LINK_K_LSB +: 5] < ACT_K_MIN)
                           ? ACT_K_MIN : st_r.wr_data[ACT_LINK_K_LSB +: 5];
               end
               if (st_r.wr_strb[2]) begin
                  // Unlisted codes fall back to live data
                  st_nxt.tp = (st_r.wr_data[ACT_LINK_TP_LSB +: 4] >
                               ACT_TP_RAMP) ? ACT_TP_DATA
                            : st_r.wr_data[ACT_LINK_TP_LSB +: 4];
               end
               if (st_r.wr_strb[2] || st_r.wr_strb[3]) begin
                  st_nxt.step = st_r.wr_data[ACT_LINK_STEP_LSB +: 8];
               end
            end
            ACT_OFS_STATUS: begin
               // Write one clears; a new edge in this cycle wins
               if (st_r.wr_strb[0] && st_r.wr_data[ACT_ST_SYSREF]
                   && !(sysref_in && !st_r.sysref_d)) begin
                  st_nxt.sysref_ev = 1'b0;
               end
            end
            ACT_OFS_PARAM, ACT_OFS_ID: st_nxt.bresp = 2'b00;
            default: st_nxt.bresp = 2'b10;
         endcase
      end

      // Read channel
      if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !st_r.rvalid) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata  = rd_mux;
         st_nxt.rresp  = (s_axi_araddr > ACT_OFS_ID ||
                          s_axi_araddr[1:0] != 2'b00) ? 2'b10 : 2'b00;
      end

      // Calibration sequencer
      case (st_r.cal)
         ACT_CS_WAIT: begin
            st_nxt.cal_done = 1'b0;
            if (!supplies_ok) begin
               st_nxt.cnt = '0;
            end else if (samp_clk_en) begin
               if (st_r.cnt == PWRUP_LAST) begin
                  st_nxt.cnt = '0;
                  st_nxt.cal = ACT_CS_CAL;
               end else begin
                  st_nxt.cnt = st_r.cnt + 24'h000001;
               end
            end
         end
         ACT_CS_CAL: begin
            st_nxt.cal_done = 1'b0;
            if (!supplies_ok) begin
               st_nxt.cnt = '0;
               st_nxt.cal = ACT_CS_WAIT;
            end else if (st_r.pdn) begin
               st_nxt.cal = ACT_CS_PDN;
            end else if (samp_clk_en) begin
               if (st_r.cnt == CAL_LAST) begin
                  st_nxt.cal      = ACT_CS_DONE;
                  st_nxt.cal_done = 1'b1;
               end else begin
                  st_nxt.cnt = st_r.cnt + 24'h000001;
               end
            end
         end
         ACT_CS_DONE: begin
            if (!supplies_ok) begin
               st_nxt.cnt      = '0;
               st_nxt.cal_done = 1'b0;
               st_nxt.cal      = ACT_CS_WAIT;
            end else if (st_r.pdn) begin
               st_nxt.cal_done = 1'b0;
               st_nxt.cal      = ACT_CS_PDN;
            end
         end
         ACT_CS_PDN: begin
            st_nxt.cal_done = 1'b0;
            if (!supplies_ok) begin
               // No calibration start without valid supplies
               st_nxt.cnt = '0;
               st_nxt.cal = ACT_CS_WAIT;
            end else if (!st_r.pdn) begin
               // Leaving power-down starts a manual run
               st_nxt.cnt = '0;
               st_nxt.cal = ACT_CS_CAL;
            end
         end
         default: begin
            st_nxt.cnt = '0;
            st_nxt.cal = ACT_CS_WAIT;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r        <= '0;
         st_r.div_sel <= ACT_DIV_RST;
         st_r.k      <= ACT_K_RST;
         st_r.tp     <= ACT_TP_RST;
         st_r.step   <= ACT_STEP_RST;
         st_r.cal    <= ACT_CS_WAIT;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Formatted samples feed the framer, ahead of the scrambler
   act_fmt u_fmt (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .samp_en    (samp_clk_en),
      .sample_in  (sample_in),
      .offset_bin (st_r.ofsbin),
      .test_sel   (st_r.tp),
      .ramp_step  (st_r.step),
      .word_out   (fmt_word),
      .word_valid (fmt_vld)
   );

   assign s_axi_awready = !st_r.wr_got[1] && !st_r.bvalid;
   assign s_axi_wready  = !st_r.wr_got[0] && !st_r.bvalid;
   assign s_axi_bvalid  = st_r.bvalid;
   assign s_axi_bresp   = st_r.bresp;
   assign s_axi_arready = !st_r.rvalid;
   assign s_axi_rvalid  = st_r.rvalid;
   assign s_axi_rdata   = st_r.rdata;
   assign s_axi_rresp   = st_r.rresp;
   assign clock_divide_setting = st_r.div_sel;
   assign cal_active    = (st_r.cal == ACT_CS_CAL);
   assign link_reinit   = st_r.reinit;
   // No polarity control exists on the lane
   assign scramble_en   = st_r.scr;
   assign multiframe_k  = st_r.k;
   assign test_select   = st_r.tp;
   assign sysref_seen   = st_r.sysref_ev;
   assign tx_word       = fmt_word;
   assign tx_word_valid = fmt_vld;
endmodule : act_ctrl
`default_nettype wire

// >>> rtl/act_fmt.sv
/*
 Sample formatter: two's complement or offset binary, or the ramp when test_sel picks it,
 marking, registered ahead of framing, scrambling and 8b/10b encoding.
 Assumes sample_in is 14-bit two's complement, MSB aligned into 16 bits.
*/
`timescale 1ns/10ps
`default_nettype none
module act_fmt
   import act_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        samp_en,
   input  wire logic [13:0] sample_in,
   input  wire logic        offset_bin,
   input  wire logic [3:0]  test_sel,
   input  wire logic [7:0]  ramp_step,
   output logic      [15:0] word_out,
   output logic             word_valid
);
   typedef struct packed {
      logic [15:0] word;
      logic [15:0] ramp;
      logic        vld;
   } act_fmt_s;

   act_fmt_s st_r;
   act_fmt_s st_nxt;

   always_comb begin
      st_nxt     = st_r;
      st_nxt.vld = samp_en;
      if (samp_en) begin
         st_nxt.ramp = st_r.ramp + {8'h00, ramp_step};
         if (test_sel == ACT_TP_RAMP) begin
            st_nxt.word = st_r.ramp;
         end else if (offset_bin) begin
            // Flip of the sign bit gives offset binary
            st_nxt.word = {sample_in, 2'b00} ^ ACT_SIGN_FLIP;
         end else begin
            st_nxt.word = {sample_in, 2'b00};
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign word_out   = st_r.word;
   assign word_valid = st_r.vld;
endmodule : act_fmt
`default_nettype wire

// >>> rtl/act_pkg.sv
/*
 Package of the converter calibration and serial transmit control block:
 register offsets, field positions, reset values, counts and enumerations.
 Assumes a 200 MHz aclk and an AXI4-Lite master outside.
*/
package act_pkg;
   localparam int          ACT_CLK_MHZ       = 200;
   // Power-up wait and calibration length, in sampling clock cycles
   localparam int          ACT_PWRUP_CYC     = 8400000;
   localparam int          ACT_CAL_CYC       = 1000000;
   // Register byte offsets
   localparam logic [7:0]  ACT_OFS_CTRL      = 8'h00;
   localparam logic [7:0]  ACT_OFS_DIV       = 8'h04;
   localparam logic [7:0]  ACT_OFS_LINK      = 8'h08;
   localparam logic [7:0]  ACT_OFS_STATUS    = 8'h0c;
   localparam logic [7:0]  ACT_OFS_PARAM     = 8'h10;
   localparam logic [7:0]  ACT_OFS_ID        = 8'h14;
   // Control register fields
   localparam int          ACT_CTRL_PDN      = 0;
   localparam int          ACT_CTRL_OFSBIN   = 1;
   // Link register fields
   localparam int          ACT_LINK_SCR      = 0;
   localparam int          ACT_LINK_K_LSB    = 8;
   localparam int          ACT_LINK_TP_LSB   = 16;
   localparam int          ACT_LINK_STEP_LSB = 20;
   // Status register fields
   localparam int          ACT_ST_CAL_DONE   = 0;
   localparam int          ACT_ST_CAL_BUSY   = 1;
   localparam int          ACT_ST_REINIT     = 2;
   localparam int          ACT_ST_SYSREF     = 3;
   // Reset values and the K minimum
   localparam logic [1:0]  ACT_DIV_RST       = 2'h0;
   localparam logic [4:0]  ACT_K_RST         = 5'h1f;
   localparam logic [4:0]  ACT_K_MIN         = 5'h08;
   localparam logic [3:0]  ACT_TP_RST        = 4'h0;
   localparam logic [7:0]  ACT_STEP_RST      = 8'h01;
   // Fixed link parameters, subclass 1 and one lane, and the offset binary sign flip
   localparam logic [2:0]  ACT_SUBCLASS      = 3'h1;
   localparam logic [4:0]  ACT_LANES         = 5'h01;
   localparam logic [7:0]  ACT_OCTETS        = 8'h02;
   localparam logic [4:0]  ACT_SAMPLES       = 5'h01;
   localparam logic [4:0]  ACT_BITS_PER_LANE = 5'h14;
   localparam logic [15:0] ACT_SIGN_FLIP     = 16'h8000;
   // Arbitrary identity value
   localparam logic [31:0] ACT_ID_VALUE      = 32'h0000_a5c1;

   typedef enum logic [3:0] {
      ACT_TP_DATA  = 4'h0,
      ACT_TP_D215  = 4'h1,
      ACT_TP_K285  = 4'h2,
      ACT_TP_ILA   = 4'h3,
      ACT_TP_PRBS7 = 4'h4,
      ACT_TP_PRB15 = 4'h5,
      ACT_TP_PRB23 = 4'h6,
      ACT_TP_RAMP  = 4'h7
   } act_tp_e;

   typedef enum {
      ACT_CS_WAIT,
      ACT_CS_CAL,
      ACT_CS_DONE,
      ACT_CS_PDN
   } act_cal_e;
endpackage : act_pkg
